// File: hw/stack_ctrl_pkg.sv
// constants for the thread stack and privilege control register
package stack_ctrl_pkg;

  // ---------------------------------------------------------------
  // register layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned BIT_UNPRIV      = 0;
  localparam int unsigned BIT_STACK_SEL   = 1;
  localparam int unsigned BIT_FP_CONTEXT  = 2;
  localparam int unsigned USED_W          = 3;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;

  // ---------------------------------------------------------------
  // exception return code fields
  // ---------------------------------------------------------------
  localparam int unsigned RET_BIT_PROCESS = 2;
  localparam int unsigned RET_BIT_THREAD  = 3;
  localparam int unsigned RET_BIT_NO_FP   = 4;

  // ---------------------------------------------------------------
  // processor mode
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_THREAD  = 2'b01,
    MODE_HANDLER = 2'b10
  } mode_e;

endpackage : stack_ctrl_pkg

// File: hw/thread_stack_privilege_control.sv
// special control register: stack select, thread privilege, fp context
`timescale 1ns/1ps
module thread_stack_privilege_control
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // software access by special register moves
  input  wire logic        i_move_write,
  input  wire logic [31:0] i_move_data,
  input  wire logic        i_mrs_read,
  input  wire logic        i_sync_barrier,
  // exception machinery
  input  wire logic        i_exc_entry,
  input  wire logic        i_exception_return,
  input  wire logic [31:0] i_return_code,
  // read answer
  output logic             o_read_valid,
  output logic [31:0]      o_read_data,
  // state seen by the core
  output logic             o_handler_mode,
  output logic             o_process_stack_active,
  output logic             o_unprivileged,
  output logic             o_fp_context_active,
  output logic             o_fp_preserve,
  output logic             o_sync_pending
);

  // ---------------------------------------------------------------
  // stored state and derived signals
  // ---------------------------------------------------------------
  stack_ctrl_pkg::mode_e mode_reg;
  logic                  fp_context_reg;
  logic                  stack_select_reg;
  logic                  unpriv_reg;
  logic                  process_stack_reg;
  logic                  sync_pending_reg;
  logic                  fp_preserve_reg;
  logic                  read_valid_reg;
  logic [31:0]           read_data_reg;
  logic [31:0]           read_next;
  logic                  in_handler;
  logic                  sw_write;
  logic                  ret_thread;
  logic                  ret_process;
  logic                  stack_select_next;

  assign in_handler  = (mode_reg == stack_ctrl_pkg::MODE_HANDLER);
  // exception events take the cycle; a software move in that cycle is lost
  assign sw_write    = i_move_write && !i_exc_entry && !i_exception_return;
  assign ret_thread  = i_return_code[stack_ctrl_pkg::RET_BIT_THREAD];
  assign ret_process = i_return_code[stack_ctrl_pkg::RET_BIT_PROCESS];

  // ---------------------------------------------------------------
  // processor mode
  // ---------------------------------------------------------------
  // reset lands in thread mode, never in handler mode
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      mode_reg <= stack_ctrl_pkg::MODE_THREAD;
    else if (i_exc_entry)
      mode_reg <= stack_ctrl_pkg::MODE_HANDLER;
    else if (i_exception_return)
    begin
      unique case (ret_thread)
        1'b1: mode_reg <= stack_ctrl_pkg::MODE_THREAD;
        1'b0: mode_reg <= stack_ctrl_pkg::MODE_HANDLER;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // stack pointer select
  // ---------------------------------------------------------------
  always_comb
  begin
    stack_select_next = stack_select_reg;
    if (i_exc_entry)
      stack_select_next = 1'b0;
    else if (i_exception_return)
      stack_select_next = ret_thread && ret_process;
    else if (sw_write && !in_handler)
      stack_select_next =
        i_move_data[stack_ctrl_pkg::BIT_STACK_SEL];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      stack_select_reg <=
        stack_ctrl_pkg::CTRL_RESET[stack_ctrl_pkg::BIT_STACK_SEL];
    else
      stack_select_reg <= stack_select_next;
  end

  // ---------------------------------------------------------------
  // privilege and fp context
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      unpriv_reg <= stack_ctrl_pkg::CTRL_RESET[stack_ctrl_pkg::BIT_UNPRIV];
    else if (sw_write)
      unpriv_reg <= i_move_data[stack_ctrl_pkg::BIT_UNPRIV];
  end

  // the fp context flag is cleared on entry once the frame decision is made
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      fp_context_reg <=
        stack_ctrl_pkg::CTRL_RESET[stack_ctrl_pkg::BIT_FP_CONTEXT];
    else if (i_exc_entry)
      fp_context_reg <= 1'b0;
    else if (i_exception_return)
      fp_context_reg <= !i_return_code[stack_ctrl_pkg::RET_BIT_NO_FP];
    else if (sw_write)
      fp_context_reg <= i_move_data[stack_ctrl_pkg::BIT_FP_CONTEXT];
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      fp_preserve_reg <= 1'b0;
    else
      fp_preserve_reg <= i_exc_entry && fp_context_reg;
  end

  // ---------------------------------------------------------------
  // effective stack pointer
  // ---------------------------------------------------------------
  // software changes only take hold at the barrier, so the stack in use
  // never moves under instructions already in flight
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      process_stack_reg <= 1'b0;
    else if (i_exc_entry)
      process_stack_reg <= 1'b0;
    else if (i_exception_return)
      process_stack_reg <= ret_thread && ret_process;
    else if (i_sync_barrier)
      process_stack_reg <= stack_select_reg && !in_handler;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sync_pending_reg <= 1'b0;
    else if (i_exc_entry || i_exception_return || i_sync_barrier)
      sync_pending_reg <= 1'b0;
    else if (stack_select_next != stack_select_reg)
      sync_pending_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_comb
  begin
    read_next = 32'h0;
    read_next[stack_ctrl_pkg::BIT_FP_CONTEXT] = fp_context_reg;
    read_next[stack_ctrl_pkg::BIT_STACK_SEL] =
      stack_select_reg && !in_handler;
    read_next[stack_ctrl_pkg::BIT_UNPRIV] = unpriv_reg;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      read_valid_reg <= 1'b0;
      read_data_reg  <= 32'h0;
    end
    else
    begin
      read_valid_reg <= i_mrs_read;
      if (i_mrs_read)
        read_data_reg <= read_next;
    end
  end

  assign o_read_valid           = read_valid_reg;
  assign o_read_data            = read_data_reg;
  assign o_handler_mode         = in_handler;
  assign o_process_stack_active = process_stack_reg;
  assign o_unprivileged         = unpriv_reg && !in_handler;
  assign o_fp_context_active    = fp_context_reg;
  assign o_fp_preserve          = fp_preserve_reg;
  assign o_sync_pending         = sync_pending_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_entry;
    i_exc_entry;
  endsequence

  sequence s_write_then_barrier;
    sw_write && !in_handler ##1
      i_sync_barrier && !i_exc_entry && !i_exception_return;
  endsequence

  a_fp_preserve_flag: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_entry |=> (o_fp_preserve == $past(fp_context_reg)))
    else $error("fp preserve does not follow fp context at entry");

  a_select_read_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_mrs_read && in_handler |=>
      !o_read_data[stack_ctrl_pkg::BIT_STACK_SEL])
    else $error("stack select read nonzero in handler mode");

  a_handler_write_drop: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_move_write && in_handler && !i_exception_return |=>
      $stable(stack_select_reg))
    else $error("handler write changed stack select");

  a_return_reload: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_exception_return && !i_exc_entry |=>
      stack_select_reg == $past(ret_thread && ret_process) &&
      o_process_stack_active == stack_select_reg)
    else $error("stack select not reloaded on return");

  a_handler_main_sp: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_entry |=>
      o_handler_mode && !o_process_stack_active && !stack_select_reg)
    else $error("handler entry not on main stack");

  a_unpriv_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    sw_write |=>
      unpriv_reg == $past(i_move_data[stack_ctrl_pkg::BIT_UNPRIV]))
    else $error("thread privilege flag not written");

  a_barrier_applies: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_write_then_barrier |=>
      o_process_stack_active ==
        $past(i_move_data[stack_ctrl_pkg::BIT_STACK_SEL], 2) &&
      !o_sync_pending)
    else $error("barrier did not apply new stack select");

  a_reserved_zero: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_read_valid |-> o_read_data[31:3] == 29'h0)
    else $error("reserved control bits read nonzero");

  a_mode_onehot: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $onehot(mode_reg))
    else $error("mode register not one-hot");

  a_entry_handler: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_exc_entry |=> in_handler)
    else $error("mode not handler after exception entry");

endmodule : thread_stack_privilege_control

// File: bench/thread_stack_privilege_control_tb_top.sv
// self-checking bench for the stack and privilege control register
`timescale 1ns/1ps
module thread_stack_privilege_control_tb_top;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_move_write = 1'b0;
  logic [31:0] i_move_data = 32'h0;
  logic        i_mrs_read = 1'b0;
  logic        i_sync_barrier = 1'b0;
  logic        i_exc_entry = 1'b0;
  logic        i_exception_return = 1'b0;
  logic [31:0] i_return_code = 32'h0;
  logic        o_read_valid, o_handler_mode, o_process_stack_active;
  logic        o_unprivileged;
  logic        o_fp_context_active, o_fp_preserve, o_sync_pending;
  logic [31:0] o_read_data;
  int          fail_count = 0;
  int          n_compared = 0;

  thread_stack_privilege_control dut
  (
    .i_clk                  (i_clk),
    .i_rst                  (i_rst),
    .i_move_write           (i_move_write),
    .i_move_data            (i_move_data),
    .i_mrs_read             (i_mrs_read),
    .i_sync_barrier         (i_sync_barrier),
    .i_exc_entry            (i_exc_entry),
    .i_exception_return     (i_exception_return),
    .i_return_code          (i_return_code),
    .o_read_valid           (o_read_valid),
    .o_read_data            (o_read_data),
    .o_handler_mode         (o_handler_mode),
    .o_process_stack_active (o_process_stack_active),
    .o_unprivileged         (o_unprivileged),
    .o_fp_context_active    (o_fp_context_active),
    .o_fp_preserve          (o_fp_preserve),
    .o_sync_pending         (o_sync_pending)
  );

  always #2.5 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one pulse per call; an idle edge always separates two calls
  task automatic op(input int kind, input logic [31:0] d);
    @(posedge i_clk);
    case (kind)
      0:
      begin
        i_move_write <= 1'b1;
        i_move_data  <= d;
      end
      1: i_mrs_read     <= 1'b1;
      2: i_sync_barrier <= 1'b1;
      3: i_exc_entry    <= 1'b1;
      default:
      begin
        i_exception_return <= 1'b1;
        i_return_code      <= d;
      end
    endcase
    @(posedge i_clk);
    {i_move_write, i_mrs_read, i_sync_barrier, i_exc_entry,
     i_exception_return} <= 5'h0;
    #1;
  endtask : op

  task automatic rd(input string nm, input logic [31:0] e);
    op(1, 32'h0);
    chk("read valid", 1, o_read_valid);
    chk(nm, e, o_read_data);
  endtask : rd

  task automatic t_reset();
    rd("reset value", 32'h0);
    chk("process stack after reset", 0, o_process_stack_active);
    chk("handler after reset", 0, o_handler_mode);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write_sync();
    op(0, 32'hFFFF_FFFF);
    chk("stack before barrier", 0, o_process_stack_active);
    chk("sync pending", 1, o_sync_pending);
    chk("unprivileged", 1, o_unprivileged);
    chk("fp context", 1, o_fp_context_active);
    rd("reserved bits", 32'h7);
    op(2, 32'h0);
    chk("stack after barrier", 1, o_process_stack_active);
    chk("sync cleared", 0, o_sync_pending);
    op(0, 32'hFFFF_FFF5);
    chk("sync set again", 1, o_sync_pending);
    op(2, 32'h0);
    chk("main stack selected", 0, o_process_stack_active);
    rd("select cleared", 32'h5);
    // write and barrier on adjacent edges, as the core issues them
    @(posedge i_clk);
    i_move_write <= 1'b1;
    i_move_data  <= 32'h0000_0007;
    @(posedge i_clk);
    i_move_write   <= 1'b0;
    i_sync_barrier <= 1'b1;
    @(posedge i_clk);
    i_sync_barrier <= 1'b0;
    #1;
    chk("back to back barrier", 1, o_process_stack_active);
    chk("back to back sync", 0, o_sync_pending);
    rd("back to back value", 32'h7);
    $display("test write and barrier done");
  endtask : t_write_sync

  task automatic t_entry();
    op(3, 32'h0);
    chk("handler entered", 1, o_handler_mode);
    chk("fp preserve", 1, o_fp_preserve);
    chk("fp cleared on entry", 0, o_fp_context_active);
    chk("handler priv", 0, o_unprivileged);
    @(posedge i_clk);
    #1;
    chk("fp preserve one cycle", 0, o_fp_preserve);
    op(0, 32'h0000_0006);
    op(2, 32'h0);
    chk("handler main stack", 0, o_process_stack_active);
    rd("select write dropped", 32'h4);
    $display("test entry done");
  endtask : t_entry

  task automatic t_returns();
    logic [31:0] codes [4];
    logic [31:0] c;
    codes = '{32'hFFFF_FFFD, 32'hFFFF_FFE9, 32'hFFFF_FFF1, 32'hFFFF_FFE5};
    foreach (codes[k])
    begin
      c = codes[k];
      op(3, 32'h0);
      op(4, c);
      chk("mode after return", {31'h0, ~c[3]}, o_handler_mode);
      chk("stack ret", {31'h0, c[3] & c[2]}, o_process_stack_active);
      chk("fp after return", {31'h0, ~c[4]}, o_fp_context_active);
      rd("read after return", {29'h0, ~c[4], c[3] & c[2], 1'b0});
    end
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd("second reset", 32'h0);
    chk("thread after reset", 0, o_handler_mode);
    chk("stack after reset", 0, o_process_stack_active);
    $display("test returns done");
  endtask : t_returns

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // guards against a hang anywhere in the sequence
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_write_sync();
    t_entry();
    t_returns();
    summarize();
  end
endmodule : thread_stack_privilege_control_tb_top
